// File: core/bus_hold_ctrl.sv
// Memory cycle sequencer with bus hold surrender and ready wait states.
// Assumes the core offers one cycle at a time by a start strobe while
// accept_out is high, and that memory and external master share clk_in.
`timescale 1ns/1ps
`default_nettype none
module bus_hold_ctrl
    import bus_hold_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              hold_n_in,
    input  wire logic              ready_in,
    input  wire logic              mem_start_in,
    input  wire logic              mem_write_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              cru_active_in,
    input  wire logic [DATA_W-1:0] data_in,
    output var  logic              accept_out,
    output var  logic              mem_done_out,
    output var  logic [DATA_W-1:0] rdata_out,
    output var  logic              core_freeze_out,
    output var  logic              cru_redrive_out,
    output var  logic [ADDR_W-1:0] addr_out,
    output var  logic              addr_oe_out,
    output var  logic [DATA_W-1:0] data_out,
    output var  logic              data_oe_out,
    output var  logic              write_strobe_n_out,
    output var  logic              write_strobe_oe_out,
    output var  logic              memory_cycle_enable_n_out,
    output var  logic              memory_cycle_enable_oe_out,
    output var  logic              data_bus_input_dir_out,
    output var  logic              data_bus_input_dir_oe_out,
    output var  logic              bus_grant_ack_out,
    output var  logic              wait_out
);

    bus_state_t  state_ff;
    bus_state_t  nxt_state;
    logic [1:0]  burst_ff;
    logic [1:0]  nxt_burst;
    logic        hold_req;
    logic        start_ok;
    logic        write_ff;
    logic        cru_held_ff;
    logic        nxt_accept;
    logic        in_cycle;

    // Clocked hold request
    hold_sampler u_hold_sampler
    (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .hold_n_in    (hold_n_in),
        .hold_req_out (hold_req)
    );

    // A start counts only while offered
    assign start_ok = mem_start_in && accept_out;

    // Next state and burst length
    always_comb
    begin
        nxt_state = state_ff;
        nxt_burst = burst_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                // [R12] no start after hold
                if (start_ok)
                begin
                    nxt_state = ST_ADDR;
                    nxt_burst = BURST_ONE;
                end
                else if (hold_req)
                    nxt_state = ST_HOLD;
            end
            ST_ADDR:
            begin
                // [R7] [R8] ready decides wait
                if (ready_in)
                    nxt_state = ST_DATA;
                else
                    nxt_state = ST_WAIT;
            end
            ST_WAIT:
            begin
                // [R10] resample each clock
                if (ready_in)
                    nxt_state = ST_DATA;
            end
            ST_DATA:
            begin
                // [R2] [R3] finish following cycle
                if (start_ok)
                begin
                    nxt_state = ST_ADDR;
                    nxt_burst = burst_ff + BURST_ONE;
                end
                else
                begin
                    nxt_burst = BURST_RST;
                    nxt_state = hold_req ? ST_HOLD : ST_IDLE;
                end
            end
            ST_HOLD:
            begin
                // [R6] [R11] release of hold
                if (!hold_req)
                    nxt_state = cru_held_ff ? ST_REDRIVE : ST_IDLE;
            end
            ST_REDRIVE:
                nxt_state = ST_IDLE;
        endcase
    end

    // [R3] [R12] offer a start only in a free slot
    always_comb
    begin
        nxt_accept = 1'b0;
        if (nxt_state == ST_IDLE)
            nxt_accept = !hold_req;
        else if (nxt_state == ST_DATA)
            nxt_accept = (burst_ff < BURST_MAX);
    end

    assign in_cycle = (nxt_state == ST_ADDR) || (nxt_state == ST_WAIT) || (nxt_state == ST_DATA);

    // Sequencer state
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_ff <= ST_IDLE;
            burst_ff <= BURST_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            burst_ff <= nxt_burst;
        end
    end

    // Cycle attributes and serial-transfer marker
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            write_ff    <= 1'b0;
            cru_held_ff <= 1'b0;
        end
        else
        begin
            if (start_ok)
                write_ff <= mem_write_in;
            // [R11] remember interrupted transfer
            if (state_ff != ST_HOLD && nxt_state == ST_HOLD)
                cru_held_ff <= cru_active_in;
        end
    end

    // Address and write data pins
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            addr_out <= ADDR_RST;
            data_out <= DATA_RST;
        end
        else
        begin
            if (start_ok || nxt_state == ST_REDRIVE)
                addr_out <= addr_in;
            if (start_ok)
                data_out <= wdata_in;
        end
    end

    // [R4] [R5] float outputs and acknowledge in hold
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            addr_oe_out                <= 1'b1;
            write_strobe_oe_out        <= 1'b1;
            memory_cycle_enable_oe_out <= 1'b1;
            data_bus_input_dir_oe_out  <= 1'b1;
            bus_grant_ack_out          <= 1'b0;
        end
        else
        begin
            addr_oe_out                <= nxt_state != ST_HOLD;
            write_strobe_oe_out        <= nxt_state != ST_HOLD;
            memory_cycle_enable_oe_out <= nxt_state != ST_HOLD;
            data_bus_input_dir_oe_out  <= nxt_state != ST_HOLD;
            bus_grant_ack_out          <= nxt_state == ST_HOLD;
        end
    end

    // Memory control pins
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            memory_cycle_enable_n_out <= 1'b1;
            data_bus_input_dir_out    <= 1'b0;
            write_strobe_n_out        <= 1'b1;
            data_oe_out               <= 1'b0;
        end
        else
        begin
            memory_cycle_enable_n_out <= !in_cycle;
            data_bus_input_dir_out    <= in_cycle && !(start_ok ? mem_write_in : write_ff);
            write_strobe_n_out        <= !(write_ff && (nxt_state == ST_WAIT
                                                     || nxt_state == ST_DATA));
            data_oe_out               <= in_cycle && (start_ok ? mem_write_in : write_ff);
        end
    end

    // Core side status
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            accept_out      <= 1'b0;
            wait_out        <= 1'b0;
            core_freeze_out <= 1'b0;
            cru_redrive_out <= 1'b0;
        end
        else
        begin
            accept_out      <= nxt_accept;
            // [R9] wait only for not-ready
            wait_out        <= nxt_state == ST_WAIT;
            // [R8] freeze while stalled
            core_freeze_out <= nxt_state == ST_WAIT || nxt_state == ST_HOLD
                            || nxt_state == ST_REDRIVE;
            cru_redrive_out <= nxt_state == ST_REDRIVE;
        end
    end

    // [R10] read data taken the clock after ready
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rdata_out    <= DATA_RST;
            mem_done_out <= 1'b0;
        end
        else
        begin
            mem_done_out <= state_ff == ST_DATA;
            if (state_ff == ST_DATA && !write_ff)
                rdata_out <= data_in;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);
    a_grant_floats_bus: assert property ( // [R4]
        bus_grant_ack_out |-> !addr_oe_out && !data_oe_out && !write_strobe_oe_out
            && !memory_cycle_enable_oe_out && !data_bus_input_dir_oe_out)
        else $error("Acknowledge high while a bus output drives");
    a_grant_tracks_hold: assert property ( // [R5]
        bus_grant_ack_out == (state_ff == ST_HOLD))
        else $error("Acknowledge disagrees with hold state");
    a_hold_release_exit: assert property ( // [R6]
        state_ff == ST_HOLD && !hold_req |=> !bus_grant_ack_out && addr_oe_out)
        else $error("Hold not left after request release");
    a_wait_holds_cycle: assert property ( // [R8]
        state_ff == ST_WAIT && !ready_in |=> state_ff == ST_WAIT && core_freeze_out)
        else $error("Wait state left without ready");
    a_wait_not_ready: assert property ( // [R9]
        state_ff == ST_ADDR && !ready_in |=> wait_out ##0 !memory_cycle_enable_n_out)
        else $error("Wait indication missing after not-ready");
    a_data_after_ready: assert property ( // [R10]
        (state_ff == ST_ADDR || state_ff == ST_WAIT) && ready_in |=> ##1 mem_done_out)
        else $error("Cycle did not complete after ready");
    a_hold_entry_slot: assert property ( // [R2]
        $rose(bus_grant_ack_out) |-> $past(state_ff) == ST_IDLE
            || $past(state_ff) == ST_DATA)
        else $error("Hold entered mid memory cycle");
    a_burst_limit: assert property ( // [R3]
        burst_ff == BURST_MAX && state_ff == ST_DATA |=> state_ff != ST_ADDR)
        else $error("More than three back-to-back memory cycles");
    a_redrive_one_clk: assert property ( // [R11]
        $fell(bus_grant_ack_out) && cru_held_ff |-> cru_redrive_out ##1 !cru_redrive_out)
        else $error("Serial address re-drive not one clock");
    a_no_start_hold: assert property ( // [R12]
        state_ff == ST_IDLE && hold_req |=> !accept_out)
        else $error("Start offered after hold decision");
    c_wait_seen:    cover property (state_ff == ST_WAIT ##1 state_ff == ST_DATA);
    c_hold_seen:    cover property ($rose(bus_grant_ack_out) ##[1:20] $fell(bus_grant_ack_out));
    c_redrive_seen: cover property (cru_redrive_out);
    c_burst_three:  cover property (burst_ff == BURST_MAX && state_ff == ST_DATA);
endmodule : bus_hold_ctrl
`default_nettype wire

// File: core/hold_sampler.sv
// Samples the active-low hold request on the system clock.
// Assumes the request is synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module hold_sampler
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic hold_n_in,
    output var  logic hold_req_out
);

    // Registered request, active high
    // [R12] clocked request sample
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            hold_req_out <= 1'b0;
        else
            hold_req_out <= !hold_n_in;
    end

endmodule : hold_sampler
`default_nettype wire

// File: pkg/bus_hold_pkg.sv
// Constants and types shared by the bus surrender and wait-state logic.
// Assumes one system clock and a synchronous active-low reset.
// Overview of operation
// [R1] External master requests the buses by pulling the active-low hold request low.
// [R2] A memory cycle in progress always finishes before the hold state is entered.
// [R3] A following memory cycle also finishes; at most three back-to-back cycles.
// [R4] In hold, address, data, strobe, cycle enable and direction float; then acknowledge.
// [R5] Grant acknowledge is high exactly while in hold with outputs floated.
// [R6] Released request ends hold, drops acknowledge, drives outputs, resumes.
// [R7] Memory drives ready high to finish next clock, low for more waits.
// [R8] Ready low in a memory cycle freezes the core until ready is high.
// [R9] Wait indication is high only while stalled by a not-ready memory.
// [R10] Ready sampled each clock; data captured on the clock after ready high.
// [R11] Hold during a serial bit transfer costs one clock re-driving its address.
// [R12] Hold request sampled on the clock; no new memory cycle once hold decided.
// [R13] External master drives lines only during acknowledge, releases before dropping request.
`default_nettype none
package bus_hold_pkg;

    localparam int ADDR_W = 15;
    localparam int DATA_W = 16;

    // Longest run of back-to-back memory cycles
    localparam logic [1:0] BURST_MAX = 2'h3;
    localparam logic [1:0] BURST_ONE = 2'h1;
    localparam logic [1:0] BURST_RST = 2'h0;

    // Reset values of the pin registers
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WAIT,
        ST_DATA,
        ST_HOLD,
        ST_REDRIVE
    } bus_state_t;

endpackage : bus_hold_pkg
`default_nettype wire

// File: verification/cpu_bus_hold_and_wait_control_tb_top.sv
// Self-checking bench for the bus surrender and wait-state controller.
// Assumes the memory partner mem_model and a 20 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_hold_and_wait_control_tb_top
    import bus_hold_pkg::*;
;
    logic clk_in = 1'b0, rst_n_in = 1'b0, hold_n_in = 1'b1, start = 1'b0, wr = 1'b0;
    logic cru = 1'b0, ready, accept, done, freeze, redrive, a_oe, d_oe, we_n, we_oe;
    logic cyc_n, cyc_oe, data_bus_input_dir, data_bus_input_dir_oe, grant, wt;
    logic [ADDR_W-1:0] addr = 15'h0000, addr_o;
    logic [DATA_W-1:0] wdata = 16'h0000, din, dout, rdata;
    logic [3:0]        waits = 4'h0;
    logic [3:0]        ctl;
    int                n_fail = 0, checks_done = 0, lat, nw;

    bus_hold_ctrl dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .hold_n_in(hold_n_in),
        .ready_in(ready), .mem_start_in(start), .mem_write_in(wr), .addr_in(addr),
        .wdata_in(wdata), .cru_active_in(cru), .data_in(din), .accept_out(accept),
        .mem_done_out(done), .rdata_out(rdata), .core_freeze_out(freeze),
        .cru_redrive_out(redrive), .addr_out(addr_o), .addr_oe_out(a_oe), .data_out(dout),
        .data_oe_out(d_oe), .write_strobe_n_out(we_n), .write_strobe_oe_out(we_oe),
        .memory_cycle_enable_n_out(cyc_n), .memory_cycle_enable_oe_out(cyc_oe),
        .data_bus_input_dir_out(data_bus_input_dir), .data_bus_input_dir_oe_out(data_bus_input_dir_oe),
        .bus_grant_ack_out(grant), .wait_out(wt));

    mem_model mem_u (.clk_in(clk_in), .waits_in(waits), .addr_in(addr_o), .wdata_in(dout),
        .cyc_n_in(cyc_n), .rd_in(data_bus_input_dir), .we_n_in(we_n), .ready_out(ready), .rdata_out(din));

    // 50 ns system clock
    always #25 clk_in = ~clk_in;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Moves n edges on, then just past the last one
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : tick

    // One memory cycle from the core side; reports edges to done and wait clocks
    task automatic mem_op(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        for (int k = 0; k < 20 && accept !== 1'b1; k++)
            tick(1);
        start = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        tick(1);
        start = 1'b0;
        // Memory control pins in the address clock
        ctl = {cyc_n, data_bus_input_dir, d_oe, we_n};
        lat = 1;
        nw = 0;
        while (done !== 1'b1 && lat < 30)
        begin
            nw += int'(wt === 1'b1 && freeze === 1'b1);
            tick(1);
            lat++;
        end
    endtask : mem_op

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_sim

    task automatic t_reset;
        chk({grant, wt, a_oe, cyc_n, d_oe}, 16'h0006);
        $display("t_reset finished");
    endtask : t_reset

    task automatic t_wait;
        mem_op(1'b0, 15'h0003, 16'h0000);
        chk(16'(lat), 16'h0003);
        chk(16'(nw), 16'h0000);
        chk(16'(ctl), 16'h0005);
        chk(rdata, 16'h5a03);
        waits = 4'h2;
        mem_op(1'b1, 15'h0005, 16'hc3a5);
        chk(16'(lat), 16'h0005);
        chk(16'(nw), 16'h0002);
        chk(16'(ctl), 16'h0003);
        waits = 4'h1;
        mem_op(1'b0, 15'h0005, 16'h0000);
        chk(rdata, 16'hc3a5);
        chk(16'(lat), 16'h0004);
        waits = 4'h0;
        $display("t_wait finished");
    endtask : t_wait

    task automatic t_hold;
        hold_n_in = 1'b0;
        tick(1);
        chk(16'(grant), 16'h0000);
        tick(1);
        chk({grant, a_oe, d_oe, we_oe, cyc_oe, data_bus_input_dir_oe, freeze, accept}, 16'h0082);
        tick(3);
        hold_n_in = 1'b1; // master let go of the bus first
        tick(1);
        chk(16'(grant), 16'h0001);
        tick(1);
        chk({grant, a_oe, cyc_oe, redrive}, 16'h0006);
        $display("t_hold finished");
    endtask : t_hold

    task automatic t_cru;
        cru = 1'b1;
        addr = 15'h1234;
        hold_n_in = 1'b0;
        tick(4);
        chk(16'(grant), 16'h0001);
        hold_n_in = 1'b1;
        tick(2);
        chk({grant, redrive, freeze}, 16'h0003);
        chk(16'(addr_o), 16'h1234);
        tick(1);
        chk(16'(redrive), 16'h0000);
        cru = 1'b0;
        $display("t_cru finished");
    endtask : t_cru

    task automatic t_burst;
        int takes, dones;
        takes = 0;
        dones = 0;
        wr = 1'b0;
        tick(2);
        for (int k = 0; k < 60 && grant !== 1'b1; k++)
        begin
            start = (accept === 1'b1);
            takes += int'(start);
            if (k == 1)
                hold_n_in = 1'b0;
            tick(1);
            dones += int'(done === 1'b1);
        end
        start = 1'b0;
        chk(16'(takes), 16'h0003);
        chk(16'(dones), 16'h0003);
        chk({grant, accept, cyc_oe}, 16'h0004);
        hold_n_in = 1'b1;
        tick(3);
        chk(16'(grant), 16'h0000);
        $display("t_burst finished");
    endtask : t_burst

    // Cuts a hang short
    initial
    begin
        #(4000 * 50);
        n_fail++;
        end_sim();
    end

    // Main sequence
    initial
    begin
        tick(10);
        t_reset();
        rst_n_in = 1'b1;
        tick(2);
        t_wait();
        t_hold();
        t_cru();
        t_burst();
        end_sim();
    end
endmodule : cpu_bus_hold_and_wait_control_tb_top
`default_nettype wire

// File: verification/mem_model.sv
// Memory partner: a 16-word store that answers after a set number of waits.
// Assumes the controller's registered pin outputs, all on one clock.
`timescale 1ns/1ps
`default_nettype none
module mem_model
    import bus_hold_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic [3:0]        waits_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              cyc_n_in,
    input  wire logic              rd_in,
    input  wire logic              we_n_in,
    output var  logic              ready_out,
    output var  logic [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] ram [16];
    logic [3:0]        wcnt_ff = 4'h0;
    logic              dclk_ff = 1'b0;

    // Known contents so reads can be predicted
    initial
    begin
        for (int i = 0; i < 16; i++)
            ram[i] = 16'h5a00 | 16'(i);
        rdata_out = 16'h0000;
    end

    assign ready_out = (wcnt_ff == waits_in);

    // Wait counter and data clock marker
    always @(posedge clk_in)
    begin
        if (cyc_n_in || dclk_ff)
        begin
            wcnt_ff <= 4'h0;
            dclk_ff <= 1'b0;
        end
        else if (ready_out)
            dclk_ff <= 1'b1;
        else
            wcnt_ff <= wcnt_ff + 4'h1;
    end

    // Store writes in the data clock; off the read, the data lines keep moving
    always @(posedge clk_in)
    begin
        if (!we_n_in && dclk_ff)
            ram[addr_in[3:0]] <= wdata_in;
        rdata_out <= rd_in ? ram[addr_in[3:0]] : ~rdata_out;
    end
endmodule : mem_model
`default_nettype wire
